// [core/eer_fifo.sv]
// Purpose: Small synchronous FIFO for read data
// Assumes: Single clock
// Notes:   Full and empty exact; no overwrite
`timescale 1ns/1ps
module eer_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,      // Clock
  input  wire logic             rst,      // Async reset, high
  input  wire logic             in_valid, // Write request
  output logic                  in_ready, // Not full
  input  wire logic [WIDTH-1:0] in_data,  // Write data
  output logic                  out_valid,// Not empty
  input  wire logic             out_ready,// Read accept
  output logic      [WIDTH-1:0] out_data  // Head word
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wp_q, wp_d, rp_q, rp_d;
  logic [AW:0]      cnt_q, cnt_d;
  logic             wr, rd;

  always_comb begin
    wr    = in_valid && in_ready;
    rd    = out_valid && out_ready;
    wp_d  = wr ? AW'(wp_q + 1'b1) : wp_q;
    rp_d  = rd ? AW'(rp_q + 1'b1) : rp_q;
    cnt_d = (AW+1)'(cnt_q + (AW+1)'(wr) - (AW+1)'(rd));
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      wp_q  <= wp_d;
      rp_q  <= rp_d;
      cnt_q <= cnt_d;
    end
  end

  always_ff @(posedge clk) begin
    if (wr) begin
      mem_q[wp_q] <= in_data;
    end
  end

  assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rp_q];
endmodule

// [core/eer_link_if.sv]
// Purpose: Two-wire link between bus master and EEPROM slave
// Assumes: Open-drain data; pin level resolved from enables here
// Notes:   Serial clock driven only by master
`timescale 1ns/1ps
interface eer_link_if;
  logic scl_o;
  logic scl_oe;
  logic sda_m_oe;
  logic sda_s_oe;
  logic scl;
  logic sda;
  // Data is an open-drain wired AND with pull-up; clock is pulled up when not driven
  assign scl = scl_oe ? scl_o : 1'b1;
  assign sda = ~(sda_m_oe | sda_s_oe);
  modport slave  (input scl, input sda, output sda_s_oe);
  modport master (input scl, input sda, output scl_o, output scl_oe, output sda_m_oe);
endinterface

// [core/eer_master.sv]
// Purpose: Two-wire master issuing random/sequential reads, data into FIFO
// Assumes: Serial clock made here by dividing MCLK
// Notes:   FIFO full stalls the read before the next acknowledge decision
`timescale 1ns/1ps
module eer_master
  import eer_pkg::*;
(
  input  wire logic        MCLK,       // System clock
  input  wire logic        SYS_RST,    // Async reset, high
  eer_link_if.master       LINK,       // Two-wire link
  input  wire logic        REQ,        // Start read, pulse
  input  wire logic [2:0]  REQ_CS,     // Chip select value
  input  wire logic [14:0] REQ_ADDR,   // Start address
  input  wire logic [7:0]  REQ_LEN,    // Bytes to read minus one
  output logic             BUSY,       // Transfer running
  output logic             NACK_ERR,   // Slave did not ack, pulse
  output logic             RD_VALID,   // Read data valid
  input  wire logic        RD_READY,   // Read data accept
  output logic [7:0]       RD_DATA     // Read data
);
  import eer_pkg::*;

  typedef enum {M_IDLE, M_START, M_BYTE, M_ACKIN, M_RBYTE, M_ACKOUT, M_RSTART,
                M_STOP} eer_mst_t;

  eer_mst_t    st_q, st_d;
  logic [3:0]  div_q, div_d;
  logic [1:0]  ph_q, ph_d;          // Quarter phase within a bit
  logic [3:0]  bit_q, bit_d;
  logic [7:0]  sh_q, sh_d, len_q, len_d;
  logic [1:0]  byte_q, byte_d;      // Bytes sent in this phase
  logic        rd_phase_q, rd_phase_d;
  logic        scl_q, scl_d, sda_oe_q, sda_oe_d, err_q, err_d, push;
  logic [2:0]  cs_q, cs_d;
  logic [14:0] addr_q, addr_d;
  logic        sda_s1_q, sda_s2_q, f_ready;
  logic        tick;
  logic        busy_q, busy_d;

  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      sda_s1_q <= 1'b1;
      sda_s2_q <= 1'b1;
    end else begin
      sda_s1_q <= LINK.sda;
      sda_s2_q <= sda_s1_q;
    end
  end

  function automatic logic [7:0] ctrl(input logic [2:0] cs, input logic dir);
    ctrl = {EER_TYPE_CODE, cs, dir}; // RULE_10
  endfunction

  always_comb begin
    div_d      = (div_q == 4'(EER_CLK_DIV/2 - 1)) ? 4'h0 : 4'(div_q + 1'b1);
    tick       = (div_q == 4'(EER_CLK_DIV/2 - 1));
    st_d       = st_q;
    ph_d       = ph_q;
    bit_d      = bit_q;
    sh_d       = sh_q;
    len_d      = len_q;
    byte_d     = byte_q;
    rd_phase_d = rd_phase_q;
    scl_d      = scl_q;
    sda_oe_d   = sda_oe_q;
    err_d      = 1'b0;
    cs_d       = cs_q;
    addr_d     = addr_q;
    push       = 1'b0;
    if (st_q == M_IDLE) begin
      if (REQ) begin
        cs_d = REQ_CS;
        addr_d = REQ_ADDR;
        len_d = REQ_LEN;
        rd_phase_d = 1'b0;
        ph_d = 2'd0;
        st_d = M_START;
      end
    end else if (tick) begin
      ph_d = 2'(ph_q + 1'b1);
      case (st_q)
        M_START, M_RSTART: begin
          // Phases: data high, clock high, data low, clock low
          case (ph_q)
            2'd0: sda_oe_d = 1'b0;
            2'd1: scl_d = 1'b1;
            2'd2: sda_oe_d = 1'b1;
            default: begin
              scl_d = 1'b0;
              sh_d  = ctrl(cs_q, rd_phase_q); // RULE_01 RULE_03
              bit_d = 4'h0;
              byte_d = 2'd0;
              st_d = M_BYTE;
            end
          endcase
        end
        M_BYTE, M_RBYTE, M_ACKIN, M_ACKOUT: begin
          case (ph_q)
            2'd0: begin
              if (st_q == M_BYTE) sda_oe_d = !sh_q[7];
              else if (st_q == M_ACKOUT) sda_oe_d = (len_q != 8'h00); // RULE_06 RULE_07
              else sda_oe_d = 1'b0;
            end
            2'd1: scl_d = 1'b1;
            2'd2: begin
              if (st_q == M_RBYTE) sh_d = {sh_q[6:0], sda_s2_q};
              if (st_q == M_ACKIN && sda_s2_q) begin
                err_d = 1'b1;
              end
            end
            default: begin
              scl_d = 1'b0;
              if (st_q == M_BYTE) begin
                sh_d  = {sh_q[6:0], 1'b0};
                bit_d = 4'(bit_q + 1'b1);
                if (bit_q == 4'h7) st_d = M_ACKIN;
              end else if (st_q == M_RBYTE) begin
                bit_d = 4'(bit_q + 1'b1);
                if (bit_q == 4'h7) st_d = M_ACKOUT;
              end else if (st_q == M_ACKIN) begin
                bit_d  = 4'h0;
                byte_d = 2'(byte_q + 1'b1);
                // Leave on the clock's low phase so the stop that follows is clean
                if (sda_s2_q) st_d = M_STOP;
                else if (rd_phase_q) st_d = M_RBYTE;
                else if (byte_q == 2'd0) begin
                  sh_d = {1'b0, addr_q[14:8]}; // RULE_11
                  st_d = M_BYTE;
                end else if (byte_q == 2'd1) begin
                  sh_d = addr_q[7:0];
                  st_d = M_BYTE;
                end else begin
                  rd_phase_d = 1'b1; // RULE_02
                  st_d = M_RSTART;
                end
              end else begin
                push  = 1'b1;
                bit_d = 4'h0;
                len_d = 8'(len_q - 1'b1);
                st_d  = (len_q == 8'h00) ? M_STOP : M_RBYTE;
              end
            end
          endcase
          // Hold ack decision while FIFO cannot take the byte
          if (st_q == M_ACKOUT && ph_q == 2'd0 && !f_ready) begin
            ph_d = ph_q;
            sda_oe_d = sda_oe_q;
          end
        end
        M_STOP: begin
          case (ph_q)
            2'd0: sda_oe_d = 1'b1;
            2'd1: scl_d = 1'b1;
            2'd2: sda_oe_d = 1'b0; // RULE_04
            default: st_d = M_IDLE;
          endcase
        end
        default: st_d = M_IDLE;
      endcase
    end
  end

  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      st_q <= M_IDLE;
      div_q <= 4'h0;
      ph_q <= 2'd0;
      bit_q <= 4'h0;
      sh_q <= 8'h00;
      len_q <= 8'h00;
      byte_q <= 2'd0;
      rd_phase_q <= 1'b0;
      scl_q <= 1'b1;
      sda_oe_q <= 1'b0;
      err_q <= 1'b0;
      cs_q <= 3'h0;
      addr_q <= 15'h0000;
      busy_q <= 1'b0;
    end else begin
      st_q <= st_d;
      div_q <= div_d;
      ph_q <= ph_d;
      bit_q <= bit_d;
      sh_q <= sh_d;
      len_q <= len_d;
      byte_q <= byte_d;
      rd_phase_q <= rd_phase_d;
      scl_q <= scl_d;
      sda_oe_q <= sda_oe_d;
      err_q <= err_d;
      cs_q <= cs_d;
      addr_q <= addr_d;
      busy_q <= busy_d;
    end
  end

  eer_fifo #(.WIDTH(EER_DATA_W), .DEPTH(EER_FIFO_DEPTH)) u_fifo (
    .clk       (MCLK),
    .rst       (SYS_RST),
    .in_valid  (push),
    .in_ready  (f_ready),
    .in_data   (sh_q),
    .out_valid (RD_VALID),
    .out_ready (RD_READY),
    .out_data  (RD_DATA)
  );

  assign LINK.scl_o    = scl_q;
  assign LINK.scl_oe   = 1'b1;
  assign LINK.sda_m_oe = sda_oe_q;
  assign busy_d        = (st_d != M_IDLE);
  assign BUSY          = busy_q;
  assign NACK_ERR      = err_q;
endmodule

// [core/eer_pkg.sv]
// Purpose: Shared constants for the two-wire EEPROM read path
// Assumes: MCLK at 250 MHz samples the serial clock and data pins
// Notes:   Device type code value is arbitrary, not tied to any part
package eer_pkg;
  localparam int          EER_ADDR_W      = 15;
  localparam int          EER_DATA_W      = 8;
  localparam int          EER_FIFO_DEPTH  = 8;
  localparam logic [3:0]  EER_TYPE_CODE   = 4'h5;     // Arbitrary value
  localparam int          EER_TYPE_POS    = 4;
  localparam int          EER_CS_POS      = 1;
  localparam int          EER_DIR_POS     = 0;
  localparam logic        EER_DIR_WRITE   = 1'b0;
  localparam logic        EER_DIR_READ    = 1'b1;
  localparam logic [14:0] EER_ADDR_RST    = 15'h0000;
  localparam logic [14:0] EER_ADDR_TOP    = 15'h7FFF;
  localparam int          EER_CLK_DIV     = 8;         // Half period of serial clock, MCLK cycles
  localparam int          EER_MASTER_DIV_W = 4;
endpackage

// [core/eer_slave.sv]
// Purpose: EEPROM slave read path: address load, random and sequential read
// Assumes: Serial pins sampled by MCLK through two flip-flops
// Notes:   Array contents loaded through a simple preload port
`timescale 1ns/1ps
// Summary of operation
// RULE_01: Master loads address using write-direction control byte
// RULE_02: Repeated start ends write, keeps loaded pointer
// RULE_03: Read control byte acknowledged, then byte shifted out
// RULE_04: No-ack plus stop ends read, data released
// RULE_05: After read, pointer is one past last byte
// RULE_06: Master ack fetches next sequential byte
// RULE_07: Master ends sequence with no-ack and stop
// RULE_08: Pointer increments after every completed byte
// RULE_09: Pointer wraps from top address to zero
// RULE_10: Acknowledge only matching type code and chip select
// RULE_11: Two address bytes, high first, top bit ignored
// RULE_12: No acknowledge while programming cycle busy
// RULE_13: Release data line after master no-ack
// RULE_14: Start or stop mid-byte abandons transfer
module eer_slave
  import eer_pkg::*;
#(
  parameter int ADDR_W = eer_pkg::EER_ADDR_W
) (
  input  wire logic          MCLK,                 // System clock
  input  wire logic          SYS_RST,              // Async reset, high
  eer_link_if.slave          LINK,                 // Two-wire link
  input  wire logic          CHIP_SELECT_BIT_TWO,  // Chip select pin 2
  input  wire logic          CHIP_SELECT_BIT_ONE,  // Chip select pin 1
  input  wire logic          CHIP_SELECT_BIT_ZERO, // Chip select pin 0
  input  wire logic          PROG_BUSY,            // Programming cycle running
  input  wire logic          LOAD_EN,              // Array preload strobe
  input  wire logic [14:0]   LOAD_ADDR,            // Preload address
  input  wire logic [7:0]    LOAD_DATA,            // Preload data
  output logic [14:0]        ADDR_PTR              // Internal address pointer
);
  import eer_pkg::*;

  typedef enum {S_IDLE, S_CTRL, S_CTRL_ACK, S_AH, S_AH_ACK, S_AL, S_AL_ACK,
                S_WAIT, S_TX, S_TX_ACK} eer_sst_t;

  logic [7:0]  mem_q [2**ADDR_W];
  logic [2:0]  scl_s_q, sda_s_q, cs_s1_q, cs_s2_q;
  logic        scl, sda, scl_rise, scl_fall, start_ev, stop_ev;
  eer_sst_t    st_q, st_d;
  logic [3:0]  bit_q, bit_d;
  logic [7:0]  sh_q, sh_d;
  logic [14:0] ptr_q, ptr_d;
  logic        oe_q, oe_d;

  // Two flops before use; third stage for edge detection
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      scl_s_q <= 3'h7;
      sda_s_q <= 3'h7;
      cs_s1_q <= 3'h0;
      cs_s2_q <= 3'h0;
    end else begin
      scl_s_q <= {scl_s_q[1:0], LINK.scl};
      sda_s_q <= {sda_s_q[1:0], LINK.sda};
      // Strap pins are outside this clock too; only the second stage is read
      cs_s1_q <= {CHIP_SELECT_BIT_TWO, CHIP_SELECT_BIT_ONE, CHIP_SELECT_BIT_ZERO};
      cs_s2_q <= cs_s1_q;
    end
  end

  always_comb begin
    scl      = scl_s_q[1];
    sda      = sda_s_q[1];
    scl_rise = scl_s_q[1] && !scl_s_q[2];
    scl_fall = !scl_s_q[1] && scl_s_q[2];
    start_ev = scl && scl_s_q[2] && !sda && sda_s_q[2];
    stop_ev  = scl && scl_s_q[2] && sda && !sda_s_q[2];
  end

  always_ff @(posedge MCLK) begin
    if (LOAD_EN) begin
      mem_q[LOAD_ADDR] <= LOAD_DATA;
    end
  end

  always_comb begin
    st_d  = st_q;
    bit_d = bit_q;
    sh_d  = sh_q;
    ptr_d = ptr_q;
    oe_d  = oe_q;
    if (start_ev) begin
      // Also a repeated start: pointer already loaded stays
      st_d  = S_CTRL; // RULE_02 RULE_14
      bit_d = 4'h0;
      oe_d  = 1'b0;
    end else if (stop_ev) begin
      st_d = S_IDLE; // RULE_04 RULE_14
      oe_d = 1'b0;
    end else begin
      case (st_q)
        S_CTRL, S_AH, S_AL: begin
          if (scl_rise) begin
            sh_d  = {sh_q[6:0], sda};
            bit_d = 4'(bit_q + 1'b1);
          end else if (scl_fall && bit_q == 4'h8) begin
            bit_d = 4'h0;
            if (st_q == S_CTRL) begin
              if (!PROG_BUSY && sh_q[7:EER_TYPE_POS] == EER_TYPE_CODE && // RULE_12 RULE_10
                  sh_q[EER_CS_POS+:3] == cs_s2_q) begin
                oe_d = 1'b1;
                st_d = S_CTRL_ACK;
              end else begin
                st_d = S_IDLE;
              end
            end else if (PROG_BUSY) begin
              st_d = S_IDLE; // RULE_12
            end else if (st_q == S_AH) begin
              ptr_d = {sh_q[6:0], ptr_q[7:0]}; // RULE_11
              oe_d  = 1'b1;
              st_d  = S_AH_ACK;
            end else begin
              ptr_d = {ptr_q[14:8], sh_q}; // RULE_01
              oe_d  = 1'b1;
              st_d  = S_AL_ACK;
            end
          end
        end
        S_CTRL_ACK: begin
          if (scl_fall) begin
            if (sh_q[EER_DIR_POS] == EER_DIR_READ) begin
              sh_d  = mem_q[ptr_q]; // RULE_03
              oe_d  = !mem_q[ptr_q][7];
              bit_d = 4'h1;
              st_d  = S_TX;
            end else begin
              oe_d = 1'b0;
              st_d = S_AH;
            end
          end
        end
        S_AH_ACK: begin
          if (scl_fall) begin
            oe_d = 1'b0;
            st_d = S_AL;
          end
        end
        S_AL_ACK: begin
          // Data bytes of a write belong to another block; wait for restart
          if (scl_fall) begin
            oe_d = 1'b0;
            st_d = S_WAIT;
          end
        end
        S_TX: begin
          if (scl_fall) begin
            if (bit_q == 4'h8) begin
              oe_d  = 1'b0;
              ptr_d = (ptr_q == EER_ADDR_TOP) ? EER_ADDR_RST // RULE_09
                                              : 15'(ptr_q + 1'b1); // RULE_08 RULE_05
              st_d  = S_TX_ACK;
            end else begin
              oe_d  = !sh_q[7 - bit_q[2:0]];
              bit_d = 4'(bit_q + 1'b1);
            end
          end
        end
        S_TX_ACK: begin
          if (scl_rise) begin
            sh_d = {7'h00, sda};
          end else if (scl_fall) begin
            if (!sh_q[0]) begin
              sh_d  = mem_q[ptr_q]; // RULE_06
              oe_d  = !mem_q[ptr_q][7];
              bit_d = 4'h1;
              st_d  = S_TX;
            end else begin
              oe_d = 1'b0; // RULE_13 RULE_07
              st_d = S_WAIT;
            end
          end
        end
        S_IDLE, S_WAIT: begin
          oe_d = 1'b0;
        end
        default: begin
          st_d = S_IDLE;
          oe_d = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      st_q  <= S_IDLE;
      bit_q <= 4'h0;
      sh_q  <= 8'h00;
      ptr_q <= EER_ADDR_RST;
      oe_q  <= 1'b0;
    end else begin
      st_q  <= st_d;
      bit_q <= bit_d;
      sh_q  <= sh_d;
      ptr_q <= ptr_d;
      oe_q  <= oe_d;
    end
  end

  assign LINK.sda_s_oe = oe_q;
  assign ADDR_PTR      = ptr_q;
endmodule

// [sim/eer_link_monitor.sv]
// Purpose: Wire-level checks on the two-wire link between master and slave
// Assumes: All signals sampled on MCLK; serial clock far slower than MCLK
// Notes:   Sees only the interface signals, instantiated beside the link
`timescale 1ns/1ps
module eer_link_monitor (
  input wire logic MCLK,     // System clock
  input wire logic SYS_RST,  // Async reset, high
  input wire logic scl,      // Resolved serial clock
  input wire logic sda,      // Resolved serial data
  input wire logic scl_o,    // Master clock value
  input wire logic scl_oe,   // Master clock enable
  input wire logic sda_m_oe, // Master pulls data low
  input wire logic sda_s_oe  // Slave pulls data low
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (SYS_RST);

  // Slave may only start pulling data while the clock is low
  AST_SLV_DRIVE_LOW_PHASE: assert property ($rose(sda_s_oe) |-> !scl)
    else $error("slave began driving data while clock high");
  // A driven bit must stay put across the whole high phase
  AST_SLV_HOLD_HIGH: assert property ($rose(scl) && sda_s_oe |-> sda_s_oe[*8])
    else $error("slave data changed during clock high");
  AST_START_SLV_QUIET: assert property ($fell(sda) && scl && $past(scl) |-> !sda_s_oe)
    else $error("slave driving at start condition");
  AST_STOP_SLV_QUIET: assert property ($rose(sda) && scl && $past(scl)
    |-> (!sda_s_oe)[*8])
    else $error("slave drove data after stop condition");
  // No upper bound: the master may hold the clock low while its FIFO is full
  AST_SCL_LOW_SPAN: assert property ($fell(scl) |-> (!scl)[*4])
    else $error("serial clock low phase too short");
  AST_SCL_HIGH_MIN: assert property ($rose(scl) |-> scl[*4])
    else $error("serial clock high phase too short");
  // Both pulling low is harmless electrically but means a lost handover
  AST_NO_FIGHT: assert property (scl && $past(scl) && sda_s_oe |-> !sda_m_oe)
    else $error("master and slave both drive data");
  AST_RESET_IDLE: assert property ($past(SYS_RST) |-> scl && !sda_m_oe && !sda_s_oe)
    else $error("link not idle after reset");

  COV_START: cover property ($fell(sda) && scl && $past(scl));
  COV_SLV_ACK: cover property ($rose(sda_s_oe));
  COV_STOP: cover property ($rose(sda) && scl && $past(scl));
  COV_MASTER_CLK: cover property (scl_oe && !scl_o);
endmodule

// [sim/tb.sv]
// Purpose: Self-checking bench for master and slave joined by the link
// Assumes: Slave array preloaded before any read
// Notes:   Expected bytes come from a fixed pattern of the address
`timescale 1ns/1ps
module tb;
  import eer_pkg::*;
  logic        mclk      = 1'b0;
  logic        sys_rst   = 1'b1;
  logic        req       = 1'b0;
  logic [2:0]  req_cs    = 3'h0;
  logic [14:0] req_addr  = 15'h0000;
  logic [7:0]  req_len   = 8'h00;
  logic        rd_ready  = 1'b1;
  logic        prog_busy = 1'b0;
  logic        load_en   = 1'b0;
  logic [14:0] load_addr = 15'h0000;
  logic [7:0]  load_data = 8'h00;
  logic [2:0]  cs_pins   = 3'h5;
  logic [14:0] bases [3] = '{15'h0000, 15'h1230, 15'h7FF8};
  logic        busy;
  logic        nack_err;
  logic        rd_valid;
  logic [7:0]  rd_data;
  logic [14:0] addr_ptr;
  int          err_count   = 0;
  int          comparisons = 0;

  always #2 mclk = ~mclk;

  eer_link_if eer_link_if_i ();

  eer_slave eer_slave_i (
    .MCLK(mclk), .SYS_RST(sys_rst), .LINK(eer_link_if_i),
    .CHIP_SELECT_BIT_TWO(cs_pins[2]), .CHIP_SELECT_BIT_ONE(cs_pins[1]),
    .CHIP_SELECT_BIT_ZERO(cs_pins[0]), .PROG_BUSY(prog_busy), .LOAD_EN(load_en),
    .LOAD_ADDR(load_addr), .LOAD_DATA(load_data), .ADDR_PTR(addr_ptr)
  );

  eer_master eer_master_i (
    .MCLK(mclk), .SYS_RST(sys_rst), .LINK(eer_link_if_i), .REQ(req), .REQ_CS(req_cs),
    .REQ_ADDR(req_addr), .REQ_LEN(req_len), .BUSY(busy), .NACK_ERR(nack_err),
    .RD_VALID(rd_valid), .RD_READY(rd_ready), .RD_DATA(rd_data)
  );

  eer_link_monitor eer_link_monitor_i (
    .MCLK(mclk), .SYS_RST(sys_rst), .scl(eer_link_if_i.scl), .sda(eer_link_if_i.sda),
    .scl_o(eer_link_if_i.scl_o), .scl_oe(eer_link_if_i.scl_oe),
    .sda_m_oe(eer_link_if_i.sda_m_oe), .sda_s_oe(eer_link_if_i.sda_s_oe)
  );

  function automatic logic [7:0] pat(input logic [14:0] a);
    return a[7:0] ^ {1'b0, a[14:8]};
  endfunction

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic print_verdict();
    if (err_count == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Stall holds the consumer off so the FIFO fills and the master must wait
  task automatic do_read(input logic [2:0] cs, input logic [14:0] a, input logic [7:0] len,
                         input bit stall, input logic exp_nack);
    logic nack;
    int   k;
    nack = 1'b0;
    k    = 0;
    @(posedge mclk);
    req      <= 1'b1;
    req_cs   <= cs;
    req_addr <= a;
    req_len  <= len;
    rd_ready <= !stall;
    @(posedge mclk);
    req <= 1'b0;
    for (int t = 0; t < 6000; t++) begin
      @(negedge mclk);
      if (nack_err === 1'b1) nack = 1'b1;
      if (rd_valid === 1'b1 && rd_ready === 1'b1) begin
        check("rd_data", {8'h00, rd_data}, {8'h00, pat(a + 15'(k))});
        k++;
      end
      if (stall && t == 2600) begin
        check("busy_while_full", {15'h0000, busy}, 16'h0001);
        check("valid_while_full", {15'h0000, rd_valid}, 16'h0001);
        @(posedge mclk);
        rd_ready <= 1'b1;
      end
      if (t > 4 && busy !== 1'b1 && rd_valid !== 1'b1) break;
    end
    check("busy_end", {15'h0000, busy}, 16'h0000);
    check("nack_seen", {15'h0000, nack}, {15'h0000, exp_nack});
    check("byte_count", 16'(k), exp_nack ? 16'h0000 : 16'(len) + 16'h0001);
    if (!exp_nack) begin
      check("addr_ptr", {1'b0, addr_ptr}, {1'b0, a + 15'(len) + 15'h0001});
    end
  endtask

  initial begin
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    for (int b = 0; b < 3; b++) begin
      for (int i = 0; i < 8; i++) begin
        @(posedge mclk);
        load_en   <= 1'b1;
        load_addr <= bases[b] + 15'(i);
        load_data <= pat(bases[b] + 15'(i));
      end
    end
    @(posedge mclk);
    load_en <= 1'b0;
    do_read(3'h5, 15'h1234, 8'h00, 1'b0, 1'b0);
    do_read(3'h5, 15'h1236, 8'h00, 1'b0, 1'b0);
    do_read(3'h5, 15'h0000, 8'h03, 1'b0, 1'b0);
    do_read(3'h5, 15'h7FFC, 8'h09, 1'b1, 1'b0);
    do_read(3'h3, 15'h0002, 8'h00, 1'b0, 1'b1);
    @(posedge mclk);
    cs_pins <= 3'h3;
    do_read(3'h3, 15'h0003, 8'h01, 1'b0, 1'b0);
    @(posedge mclk);
    prog_busy <= 1'b1;
    do_read(3'h3, 15'h0001, 8'h00, 1'b0, 1'b1);
    @(posedge mclk);
    prog_busy <= 1'b0;
    do_read(3'h3, 15'h1230, 8'h00, 1'b0, 1'b0);
    print_verdict();
  end

  // Longest expected run is near 7700 cycles; this leaves ample margin
  initial begin
    repeat (40000) @(posedge mclk);
    err_count++;
    print_verdict();
  end
endmodule
